/* verilog/shc_top.sv */
// Operation
// - two stages each compare the sign of the sum of two differential pairs.
// - sense above centre plus half-band clears the latch, below centre minus it sets it.
// - the input switches swap between plus and minus of each pair once per sample.
// - the pulsed supply is driven only during the active window, else released.
// - samples start by themselves from an internal oscillator of set period.
// - with an external timer source, a sample starts about 5 us after its rise.
// - with the shortest period, samples run back to back limited by the window.
// - the window is a fixed 80 us; the pulsed supply pulse is one clock shorter.
`timescale 1ns/10ps
`default_nettype none
module shc_top
	import shc_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     rst_b,
	input  wire logic                     ext_timer_sel,
	input  wire logic                     sample_timer_pin,
	input  wire logic [OSC_W-1:0]         osc_period,
	input  wire logic signed [DATA_W-1:0] sense_input,
	input  wire logic signed [DATA_W-1:0] set_point,
	input  wire logic signed [DATA_W-1:0] half_band,
	output logic                          pulsed_supply_out,
	output logic                          pulsed_supply_oe,
	output logic                          input_swap,
	output logic                          on_off_out
);
	shc_state_e       state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [OSC_W-1:0] osc_cnt_r;
	logic             osc_tick;
	logic             pin_d_r;
	logic             ext_tick;
	logic             tick;
	logic             upper_hit;
	logic             lower_ok;
	logic             latch_nxt;
	logic             oe_nxt;
	logic             swap_nxt;
	logic             seq_last;
	logic [1:0]       stage_hit;
	logic [OSC_W-1:0] osc_nxt;
	shc_state_e       state_nxt;
	logic signed [DATA_W-1:0] stage_pos [2];
	logic signed [DATA_W-1:0] stage_neg [2];
	genvar            g;
	logic             decide;
	logic signed [DATA_W-1:0] zero_v;

	assign zero_v = '0;

	// free-running oscillator; a period of zero or one reloads every cycle
	// and gives back-to-back samples paced only by the window
	always_comb begin
		if (ext_timer_sel || osc_tick) begin
			osc_nxt = '0;
		end else begin
			osc_nxt = osc_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			osc_cnt_r <= '0;
		end else begin
			osc_cnt_r <= osc_nxt;
		end
	end
	// ticks keep coming during a window; the sequencer drops them
	assign osc_tick = !ext_timer_sel
		&& (osc_cnt_r + 1'b1 >= osc_period);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_d_r <= 1'b0;
		end else begin
			pin_d_r <= sample_timer_pin;
		end
	end
	assign ext_tick = ext_timer_sel && sample_timer_pin && !pin_d_r;
	assign tick = osc_tick || ext_tick;

	// only the delay and active phases have an end count
	always_comb begin
		seq_last = 1'b0;
		case (state_r)
			SHC_DELAY: begin
				seq_last = (cnt_r == EXT_LAST);
			end
			SHC_ACTIVE: begin
				seq_last = (cnt_r == ACTIVE_LAST);
			end
			default: begin
				seq_last = 1'b0;
			end
		endcase
	end

	// sampling sequencer; ticks outside idle are dropped, not queued
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SHC_IDLE: begin
				if (ext_tick) begin
					state_nxt = SHC_DELAY;
				end else if (tick) begin
					state_nxt = SHC_ACTIVE;
				end
			end
			SHC_DELAY: begin
				if (seq_last) begin
					state_nxt = SHC_ACTIVE;
				end
			end
			SHC_ACTIVE: begin
				if (seq_last) begin
					state_nxt = SHC_IDLE;
				end
			end
			default: begin
				state_nxt = SHC_IDLE;
			end
		endcase
	end

	// one phase step per edge at most
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_r <= SHC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// phase counter restarts on every phase change and rests in idle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cnt_r <= '0;
		end else if (state_nxt != state_r) begin
			cnt_r <= '0;
		end else if (state_r == SHC_IDLE) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// enable and swap drop on the same last count, so the switches never
	// toggle while the supply is already released
	always_comb begin
		oe_nxt   = (state_r == SHC_ACTIVE) && !seq_last;
		swap_nxt = oe_nxt && (cnt_r >= (ACTIVE_LAST >> 1));
	end

	// supply drives high only in the window, released otherwise
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pulsed_supply_oe <= 1'b0;
		end else begin
			pulsed_supply_oe <= oe_nxt;
		end
	end
	assign pulsed_supply_out = 1'b1;

	// first half of window charges, second half discharges the sample caps
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			input_swap <= 1'b0;
		end else begin
			input_swap <= swap_nxt;
		end
	end

	// two stages differ only in which side of the band they watch
	generate
		for (g = 0; g < 2; g++) begin : g_stage
			if (g == 0) begin : g_upper
				// sense - set - half > 0
				assign stage_pos[g] = sense_input;
				assign stage_neg[g] = set_point;
			end else begin : g_lower
				// set - sense - half > 0
				assign stage_pos[g] = set_point;
				assign stage_neg[g] = sense_input;
			end
			shc_compare u_cmp (
				.pa_pos (stage_pos[g]),
				.pa_neg (stage_neg[g]),
				.pb_pos (zero_v),
				.pb_neg (half_band),
				.result (stage_hit[g])
			);
		end
	endgenerate
	assign upper_hit = stage_hit[0];
	assign lower_ok  = stage_hit[1];

	// decide after settling, once per window; inputs are trusted steady then
	assign decide = (state_r == SHC_ACTIVE) && (cnt_r == SETTLE_LAST);

	// inside the band, and between windows, the latch keeps its value
	always_comb begin
		latch_nxt = on_off_out;
		if (decide && upper_hit) begin
			latch_nxt = 1'b0;
		end else if (decide && lower_ok) begin
			latch_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			on_off_out <= LATCH_RST;
		end else begin
			on_off_out <= latch_nxt;
		end
	end
endmodule
`default_nettype wire

/* verilog/shc_pkg.sv */
package shc_pkg;
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned ACTIVE_US      = 80;
	localparam int unsigned SETTLE_US      = 4;
	localparam int unsigned EXT_DELAY_US   = 5;
	localparam int unsigned ACTIVE_CYC     = ACTIVE_US * CLK_MHZ;
	localparam int unsigned SETTLE_CYC     = SETTLE_US * CLK_MHZ;
	localparam int unsigned EXT_DELAY_CYC  = EXT_DELAY_US * CLK_MHZ;
	localparam int unsigned HYST_FACTOR    = 2;
	localparam int unsigned DATA_W         = 16;
	localparam int unsigned CNT_W          = 13;
	localparam int unsigned OSC_W          = 24;
	localparam logic [OSC_W-1:0] OSC_DEFAULT = 24'h00c350;
	localparam logic [CNT_W-1:0] ACTIVE_LAST = CNT_W'(ACTIVE_CYC - 1);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
	localparam logic [CNT_W-1:0] EXT_LAST    = CNT_W'(EXT_DELAY_CYC - 1);
	localparam logic             LATCH_RST   = 1'b0;
	typedef enum logic [1:0] {
		SHC_IDLE,
		SHC_DELAY,
		SHC_ACTIVE
	} shc_state_e;
endpackage

/* verilog/shc_compare.sv */
`timescale 1ns/10ps
`default_nettype none
// one comparison stage: sign of the sum of two differential pairs
module shc_compare
	import shc_pkg::*;
(
	input  wire logic signed [DATA_W-1:0] pa_pos,
	input  wire logic signed [DATA_W-1:0] pa_neg,
	input  wire logic signed [DATA_W-1:0] pb_pos,
	input  wire logic signed [DATA_W-1:0] pb_neg,
	output logic                          result
);
	logic signed [DATA_W+1:0] sum;

	always_comb begin
		sum = (DATA_W+2)'(pa_pos) - (DATA_W+2)'(pa_neg)
		    + (DATA_W+2)'(pb_pos) - (DATA_W+2)'(pb_neg);
		result = (sum > 0);
	end
endmodule
`default_nettype wire

/* test/shc_chk_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module shc_chk
	import shc_pkg::*;
(
	input wire logic sys_clk, rst_b, pulsed_supply_oe, pulsed_supply_out,
	input wire logic input_swap, on_off_out,
	input wire logic signed [DATA_W-1:0] sense_input, set_point, half_band
);
	logic [11:0] on_r;
	wire signed [DATA_W-1:0] lo = set_point - half_band;
	wire signed [DATA_W-1:0] hi = set_point + half_band;
	// cycles the pulsed supply has been driven in this window
	always_ff @(posedge sys_clk) on_r <= pulsed_supply_oe ? on_r + 12'h1 : '0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	win_len_a: assert property ($fell(pulsed_supply_oe) |-> $past(on_r) == 12'hf9e)
		else $error("window length wrong");
	win_cap_a: assert property (on_r <= 12'hf9f)
		else $error("window extended");
	swap_mid_a: assert property ($rose(input_swap) |-> on_r == 12'h7cf)
		else $error("swap at wrong time");
	swap_off_a: assert property (!pulsed_supply_oe |-> !input_swap)
		else $error("swap outside window");
	latch_when_a: assert property ($changed(on_off_out) |-> on_r == 12'hc7)
		else $error("latch moved outside decide point");
	latch_set_a: assert property (on_r == 12'hc7 && sense_input < lo |-> on_off_out)
		else $error("latch not set");
	latch_clr_a: assert property (on_r == 12'hc7 && sense_input > hi |-> !on_off_out)
		else $error("latch not cleared");
	supply_drv_a: assert property (pulsed_supply_oe |-> pulsed_supply_out)
		else $error("pulsed supply not high");
	rst_out_a: assert property ($rose(rst_b) |-> !pulsed_supply_oe && !on_off_out)
		else $error("outputs not idle after reset");
endmodule
bind shc_top shc_chk i_chk (.*);
`default_nettype wire

/* test/shc_net.sv */
`timescale 1ns/10ps
`default_nettype none
module shc_net
	import shc_pkg::*;
(
	input wire logic sys_clk, pulsed_supply_out, pulsed_supply_oe,
	input wire logic signed [DATA_W-1:0] level,
	output logic signed [DATA_W-1:0] sense_input
);
	logic signed [DATA_W-1:0] held_r;
	// level is frozen while powered; unpowered, show the inverse, never stale
	always_ff @(posedge sys_clk) if (!pulsed_supply_oe) held_r <= level;
	assign sense_input = (pulsed_supply_oe && pulsed_supply_out) ? held_r : ~held_r;
endmodule
`default_nettype wire

/* test/sampled_hysteresis_controller_test.sv */
`timescale 1ns/10ps
`default_nettype none
module sampled_hysteresis_controller_test;
	import shc_pkg::*;
	logic sys_clk = 0, rst_b = 0, ext_timer_sel = 0, sample_timer_pin = 0;
	logic [OSC_W-1:0] osc_period = '0;
	logic signed [DATA_W-1:0] level = '0, sense_input;
	logic signed [DATA_W-1:0] set_point = 16'h0100, half_band = 16'h0010;
	logic pulsed_supply_out, pulsed_supply_oe, input_swap, on_off_out;
	logic [15:0] lv [5] = '{16'h00e0, 16'h0110, 16'h0111, 16'h00f0, 16'h00ef};
	logic [4:0] ex = 5'h13;
	int n_mismatch = 0, n_compared = 0, w;
	always #10 sys_clk = ~sys_clk;
	shc_top i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ext_timer_sel(ext_timer_sel),
		.sample_timer_pin(sample_timer_pin), .osc_period(osc_period),
		.sense_input(sense_input), .set_point(set_point), .half_band(half_band),
		.pulsed_supply_out(pulsed_supply_out), .pulsed_supply_oe(pulsed_supply_oe),
		.input_swap(input_swap), .on_off_out(on_off_out));
	shc_net i_net (.sys_clk(sys_clk), .pulsed_supply_out(pulsed_supply_out),
		.pulsed_supply_oe(pulsed_supply_oe), .level(level), .sense_input(sense_input));
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (e !== g) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// w ends as the number of edges until the supply enable reads v
	task automatic wait_oe(input logic v);
		for (w = 0; pulsed_supply_oe !== v; w++) begin
			if (w > 20000) begin
				n_mismatch++;
				give_verdict();
			end
			@(posedge sys_clk);
			#1;
		end
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1;
		#1 chk("enable", 0, pulsed_supply_oe);
		chk("latch", 0, on_off_out);
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk) level <= lv[i];
			repeat (2) begin
				wait_oe(1);
				wait_oe(0);
			end
			chk("width", 16'h0f9f, 16'(w));
			chk("latch", 16'(ex[i]), on_off_out);
		end
		@(posedge sys_clk) ext_timer_sel <= 1;
		repeat (3) @(posedge sys_clk);
		#1 wait_oe(0);
		@(posedge sys_clk) sample_timer_pin <= 1;
		#1 wait_oe(1);
		chk("delay", 16'h00fc, 16'(w));
		@(posedge sys_clk) sample_timer_pin <= 0;
		@(posedge sys_clk) sample_timer_pin <= 1;
		#1 wait_oe(0);
		repeat (300) @(posedge sys_clk);
		#1 chk("retick", 0, pulsed_supply_oe);
		give_verdict();
	end
endmodule
`default_nettype wire
